//--- hw/enhanced_pwm_shutdown.sv
// enhanced pwm output stage with dead band, auto-shutdown, ahb-lite regs
`timescale 1ns/1ps
module enhanced_pwm_shutdown (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output wire logic        hreadyout,
   output wire logic [31:0] hrdata,
   output wire logic        hresp,
   input  wire logic        int_pin,
   input  wire logic        comparator_out,
   input  wire logic        aux_timer_tick,
   output wire logic        primary_output_o,
   output wire logic        primary_output_oe,
   output wire logic        complement_output_o,
   output wire logic        complement_output_oe,
   output wire logic        period_timer_flag
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      epwm_pkg::bus_e bus;
      logic [7:0]     addr;
      logic           hready;
      logic [31:0]    hrdata;
      logic           resp;
      logic [7:0]     ccp_ctrl;
      logic [7:0]     duty_high;
      logic [7:0]     duty_shadow;
      logic [1:0]     duty_low_latch;
      logic [7:0]     period_limit;
      logic [2:0]     timer_ctrl;
      logic [3:0]     presc;
      logic [9:0]     base;
      logic           timer_flag;
      logic [7:0]     db_ctrl;
      logic [7:0]     shut_ctrl;
      logic [1:0]     pin_dir;
      logic           cmp_sync_en;
      logic [1:0]     int_sync;
      logic [1:0]     cmp_sync;
      logic           cmp_held;
      logic           running;
      logic           prim_o;
      logic           prim_oe;
      logic           comp_o;
      logic           comp_oe;
   } state_s;

   state_s     s_q;
   state_s     s_d;
   logic       accept;
   logic       wr;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   logic [3:0] presc_max;
   logic       timer_on;
   logic       tick;
   logic       wrap;
   logic       pwm_level;
   logic       half;
   logic       pwm_mode;
   logic       cmp_eff;
   logic       cond;
   logic       shut_wr;
   logic [1:0] raw_act;
   logic [1:0] dly_act;

   assign hreadyout            = s_q.hready;
   assign hrdata               = s_q.hrdata;
   assign hresp                = s_q.resp;
   assign primary_output_o     = s_q.prim_o;
   assign primary_output_oe    = s_q.prim_oe;
   assign complement_output_o  = s_q.comp_o;
   assign complement_output_oe = s_q.comp_oe;
   assign period_timer_flag    = s_q.timer_flag;

   // ---------------------------------------------------------------
   // bus decode helpers
   // ---------------------------------------------------------------
   assign accept  = hsel && htrans[1] && hready && s_q.hready;
   assign wr      = (s_q.bus == epwm_pkg::BUS_WRITE);
   assign wbyte   = hwdata[7:0];
   assign shut_wr = wr && (s_q.addr == epwm_pkg::OFS_SHUT_CTRL);

   // ---------------------------------------------------------------
   // time base: 8-bit count over 2 low bits of prescaled clock
   // ---------------------------------------------------------------
   always_comb begin
      if (s_q.timer_ctrl[1:0] == epwm_pkg::PRESC_1) begin
         presc_max = epwm_pkg::PRESC_MAX_1;
      end else if (s_q.timer_ctrl[1:0] == epwm_pkg::PRESC_4) begin
         presc_max = epwm_pkg::PRESC_MAX_4;
      end else begin
         presc_max = epwm_pkg::PRESC_MAX_16;
      end
   end

   assign timer_on  = s_q.timer_ctrl[epwm_pkg::TIMER_ON_BIT];
   assign tick      = timer_on && (s_q.presc == presc_max);
   assign wrap      = tick && (s_q.base == {s_q.period_limit, 2'h3});
   assign pwm_level = s_q.base < {s_q.duty_shadow, s_q.duty_low_latch};
   assign half      = (s_q.ccp_ctrl[epwm_pkg::MODE_HI:epwm_pkg::MODE_LO]
                       == epwm_pkg::MODE_HALF);
   assign pwm_mode  = (s_q.ccp_ctrl[epwm_pkg::PWM_SEL_HI:epwm_pkg::PWM_SEL_LO]
                       == epwm_pkg::PWM_SELECT);

   // ---------------------------------------------------------------
   // shutdown sources
   // ---------------------------------------------------------------
   // with sync on, the comparator is only looked at on aux timer ticks
   assign cmp_eff = s_q.cmp_sync_en ? s_q.cmp_held
                                    : s_q.cmp_sync[1];
   assign cond    = (s_q.shut_ctrl[epwm_pkg::SRC_CMP_BIT] && cmp_eff)
                 || (s_q.shut_ctrl[epwm_pkg::SRC_INT_BIT]
                     && !s_q.int_sync[1]);

   // ---------------------------------------------------------------
   // dead band stages, one per output
   // ---------------------------------------------------------------
   assign raw_act[0] = s_q.running && pwm_level;
   assign raw_act[1] = s_q.running && half && !pwm_level;

   for (genvar i = 0; i < 2; i++) begin : g_db
      dead_band_if link ();
      assign link.in_active = raw_act[i];
      assign link.count     = half ? s_q.db_ctrl[epwm_pkg::DB_COUNT_W-1:0]
                                   : '0;
      assign dly_act[i]     = link.out_active;
      dead_band_delay u_dly (
         .hclk    (hclk),
         .hresetn (hresetn),
         .link    (link)
      );
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      if (s_q.addr == epwm_pkg::OFS_CCP_CTRL) begin
         rd_byte = s_q.ccp_ctrl;
      end else if (s_q.addr == epwm_pkg::OFS_DUTY_HIGH) begin
         rd_byte = s_q.duty_high;
      end else if (s_q.addr == epwm_pkg::OFS_DUTY_SHADOW) begin
         rd_byte = s_q.duty_shadow;
      end else if (s_q.addr == epwm_pkg::OFS_PERIOD_LIMIT) begin
         rd_byte = s_q.period_limit;
      end else if (s_q.addr == epwm_pkg::OFS_TIMER_CTRL) begin
         rd_byte = {5'h00, s_q.timer_ctrl};
      end else if (s_q.addr == epwm_pkg::OFS_TIMER_COUNT) begin
         rd_byte = s_q.base[9:2];
      end else if (s_q.addr == epwm_pkg::OFS_TIMER_STAT) begin
         rd_byte = {7'h00, s_q.timer_flag};
      end else if (s_q.addr == epwm_pkg::OFS_DB_CTRL) begin
         rd_byte = s_q.db_ctrl;
      end else if (s_q.addr == epwm_pkg::OFS_SHUT_CTRL) begin
         rd_byte = s_q.shut_ctrl;
      end else if (s_q.addr == epwm_pkg::OFS_PIN_DIR) begin
         rd_byte = {6'h00, s_q.pin_dir};
      end else if (s_q.addr == epwm_pkg::OFS_AUX_CTRL) begin
         rd_byte = {7'h00, s_q.cmp_sync_en};
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.resp     = epwm_pkg::AHB_OKAY;
      s_d.int_sync = {s_q.int_sync[0], int_pin};
      s_d.cmp_sync = {s_q.cmp_sync[0], comparator_out};
      if (aux_timer_tick) begin
         s_d.cmp_held = s_q.cmp_sync[1];
      end

      // reads take one wait state so a write just before is seen
      case (s_q.bus)
         epwm_pkg::BUS_READ: begin
            s_d.hrdata = {24'h000000, rd_byte};
            s_d.hready = 1'b1;
            s_d.bus    = epwm_pkg::BUS_IDLE;
         end
         default: begin
            s_d.bus = epwm_pkg::BUS_IDLE;
            if (accept) begin
               s_d.addr   = (haddr[31:8] == 24'h000000) ? haddr[7:0]
                                                      : epwm_pkg::ADDR_UNMAPPED;
               s_d.bus    = hwrite ? epwm_pkg::BUS_WRITE
                                   : epwm_pkg::BUS_READ;
               s_d.hready = hwrite;
            end
         end
      endcase

      // auto-restart clear comes first so any set below wins
      if (s_q.db_ctrl[epwm_pkg::RESTART_BIT] && !cond) begin
         s_d.shut_ctrl[epwm_pkg::STATUS_BIT] = 1'b0;
      end

      if (wr) begin
         if (s_q.addr == epwm_pkg::OFS_CCP_CTRL) begin
            s_d.ccp_ctrl = wbyte & epwm_pkg::CCP_CTRL_MASK;
         end else if (s_q.addr == epwm_pkg::OFS_DUTY_HIGH) begin
            s_d.duty_high = wbyte;
         end else if (s_q.addr == epwm_pkg::OFS_PERIOD_LIMIT) begin
            s_d.period_limit = wbyte;
         end else if (s_q.addr == epwm_pkg::OFS_TIMER_CTRL) begin
            s_d.timer_ctrl = wbyte[epwm_pkg::TIMER_CTRL_W-1:0];
         end else if (s_q.addr == epwm_pkg::OFS_TIMER_STAT) begin
            if (!wbyte[epwm_pkg::FLAG_BIT]) begin
               s_d.timer_flag = 1'b0;
            end
         end else if (s_q.addr == epwm_pkg::OFS_DB_CTRL) begin
            s_d.db_ctrl = wbyte;
         end else if (s_q.addr == epwm_pkg::OFS_SHUT_CTRL) begin
            s_d.shut_ctrl[epwm_pkg::STATUS_BIT-1:0] =
               wbyte[epwm_pkg::STATUS_BIT-1:0];
            if (wbyte[epwm_pkg::STATUS_BIT]) begin
               s_d.shut_ctrl[epwm_pkg::STATUS_BIT] = 1'b1;
            end else if (!cond) begin
               s_d.shut_ctrl[epwm_pkg::STATUS_BIT] = 1'b0;
            end
         end else if (s_q.addr == epwm_pkg::OFS_PIN_DIR) begin
            s_d.pin_dir = wbyte[epwm_pkg::PIN_DIR_W-1:0];
         end else if (s_q.addr == epwm_pkg::OFS_AUX_CTRL) begin
            s_d.cmp_sync_en = wbyte[epwm_pkg::CMP_SYNC_BIT];
         end
      end

      if (cond) begin
         s_d.shut_ctrl[epwm_pkg::STATUS_BIT] = 1'b1;
      end

      // time base and period events
      if (tick) begin
         s_d.presc = '0;
         s_d.base  = wrap ? '0 : 10'(s_q.base + 1'b1);
      end else if (timer_on) begin
         s_d.presc = 4'(s_q.presc + 1'b1);
      end
      if (wrap) begin
         s_d.timer_flag     = 1'b1;
         s_d.duty_shadow    = s_q.duty_high;
         s_d.duty_low_latch =
            s_q.ccp_ctrl[epwm_pkg::DUTY_LOW_HI:epwm_pkg::DUTY_LOW_LO];
      end

      // waveform waits for a fresh period after enable or restart
      if (!pwm_mode || s_d.shut_ctrl[epwm_pkg::STATUS_BIT]) begin
         s_d.running = 1'b0;
      end else if (wrap) begin
         s_d.running = 1'b1;
      end

      // pins: shutdown state overrides, polarity applied otherwise
      if (s_d.shut_ctrl[epwm_pkg::STATUS_BIT]) begin
         s_d.prim_o = !s_d.shut_ctrl[epwm_pkg::PSS_P_HI]
                   && s_d.shut_ctrl[epwm_pkg::PSS_P_LO];
         s_d.comp_o = !s_d.shut_ctrl[epwm_pkg::PSS_C_HI]
                   && s_d.shut_ctrl[epwm_pkg::PSS_C_LO];
      end else begin
         s_d.prim_o = dly_act[0]
                   ^ s_q.ccp_ctrl[epwm_pkg::POL_PRIMARY];
         s_d.comp_o = dly_act[1]
                   ^ s_q.ccp_ctrl[epwm_pkg::POL_COMPLEMENT];
      end
      s_d.prim_oe = pwm_mode && !s_q.pin_dir[epwm_pkg::DIR_PRIMARY]
                 && !(s_d.shut_ctrl[epwm_pkg::STATUS_BIT]
                      && s_d.shut_ctrl[epwm_pkg::PSS_P_HI]);
      s_d.comp_oe = pwm_mode && half
                 && !s_q.pin_dir[epwm_pkg::DIR_COMPLEMENT]
                 && !(s_d.shut_ctrl[epwm_pkg::STATUS_BIT]
                      && s_d.shut_ctrl[epwm_pkg::PSS_C_HI]);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q              <= '0;
         s_q.bus          <= epwm_pkg::BUS_IDLE;
         s_q.hready       <= 1'b1;
         s_q.period_limit <= epwm_pkg::PERIOD_LIMIT_RST;
         s_q.pin_dir      <= epwm_pkg::PIN_DIR_RST;
         s_q.int_sync     <= epwm_pkg::INT_SYNC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_flag_on_wrap : assert property (
      @(posedge hclk) disable iff (!hresetn)
      wrap |=> s_q.timer_flag)
      else $error("period flag not set at period start");

   a_duty_latch_hold : assert property (
      @(posedge hclk) disable iff (!hresetn)
      !wrap |=> $stable(s_q.duty_shadow))
      else $error("duty shadow changed mid period");

   a_start_on_period : assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(s_q.running) |-> $past(wrap))
      else $error("waveform started outside a period start");

   a_cond_sets_status : assert property (
      @(posedge hclk) disable iff (!hresetn)
      cond |=> s_q.shut_ctrl[epwm_pkg::STATUS_BIT])
      else $error("shutdown condition did not set status");

   a_fw_write_ignored : assert property (
      @(posedge hclk) disable iff (!hresetn)
      shut_wr && cond && !wbyte[epwm_pkg::STATUS_BIT]
      |=> s_q.shut_ctrl[epwm_pkg::STATUS_BIT])
      else $error("status cleared while condition persists");

   a_auto_restart : assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_q.db_ctrl[epwm_pkg::RESTART_BIT] && !cond && !shut_wr
      |=> !s_q.shut_ctrl[epwm_pkg::STATUS_BIT])
      else $error("auto-restart did not clear status");

   a_primary_forced : assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_q.shut_ctrl[epwm_pkg::STATUS_BIT]
      |-> (s_q.shut_ctrl[epwm_pkg::PSS_P_HI] ? !s_q.prim_oe
           : s_q.prim_o == s_q.shut_ctrl[epwm_pkg::PSS_P_LO]))
      else $error("primary pin not in its shutdown state");

   a_comp_forced : assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_q.shut_ctrl[epwm_pkg::STATUS_BIT]
      |-> (s_q.shut_ctrl[epwm_pkg::PSS_C_HI] ? !s_q.comp_oe
           : s_q.comp_o == s_q.shut_ctrl[epwm_pkg::PSS_C_LO]))
      else $error("complement pin not in its shutdown state");

   a_pins_released : assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_q.ccp_ctrl == 8'h00 |=> !s_q.prim_oe && !s_q.comp_oe)
      else $error("pins driven with control register cleared");

   a_single_no_comp : assert property (
      @(posedge hclk) disable iff (!hresetn)
      !half |=> !s_q.comp_oe)
      else $error("complement pin driven outside half-bridge");
endmodule

//--- hw/epwm_pkg.sv
// register map, field layout and timing constants of the enhanced pwm
// Functional notes
// - bridge mode field: 00 selects single output, 10 selects half-bridge.
// - half-bridge drives modulated signal on primary, its complement on other.
// - half-bridge delays each output's activation by count times four clocks.
// - dead band longer than active time keeps that output inactive all cycle.
// - two low mode bits pick active-high or active-low per output.
// - after enable, no waveform until the next period begins.
// - cleared control register releases all pins; unused pins stay released.
// - period timer flag rises as each new period begins.
// - reset makes all pins inputs and restores all register reset values.
// - source field: x0 comparator off, bit 0 comparator, bit 2 low int pin.
// - firmware setting the status bit is itself a shutdown event.
// - shutdown sets status; it stays until firmware or auto-restart clears.
// - shutdown forces enabled pins to their programmed states at once.
// - primary shutdown state: 00 low, 01 high, 1x high impedance.
// - complement shutdown state: 00 low, 01 high, 1x high impedance.
// - shutdown is level based and persists while the source level stays.
// - status writes are ignored while a shutdown condition persists.
// - after restart, output resumes only at the next period start.
// - with auto-restart, hardware clears status once the condition is gone.
// - comparator sync makes comparator shutdowns wait for the aux timer.
// - dead band applies only on inactive to active transitions.
// - new ten-bit duty value is latched only when a period completes.
package epwm_pkg;
   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CCP_CTRL     = 8'h00;
   localparam logic [7:0] OFS_DUTY_HIGH    = 8'h04;
   localparam logic [7:0] OFS_DUTY_SHADOW  = 8'h08;
   localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h0C;
   localparam logic [7:0] OFS_TIMER_CTRL   = 8'h10;
   localparam logic [7:0] OFS_TIMER_COUNT  = 8'h14;
   localparam logic [7:0] OFS_TIMER_STAT   = 8'h18;
   localparam logic [7:0] OFS_DB_CTRL      = 8'h1C;
   localparam logic [7:0] OFS_SHUT_CTRL    = 8'h20;
   localparam logic [7:0] OFS_PIN_DIR      = 8'h24;
   localparam logic [7:0] OFS_AUX_CTRL     = 8'h28;
   localparam logic [7:0] ADDR_UNMAPPED    = 8'hFC;
   // -----------------------------------------------------------------
   // fields and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] CCP_CTRL_MASK    = 8'hBF;
   localparam int         MODE_HI          = 7;
   localparam int         MODE_LO          = 6;
   localparam logic [1:0] MODE_SINGLE      = 2'h0;
   localparam logic [1:0] MODE_HALF        = 2'h2;
   localparam int         DUTY_LOW_HI      = 5;
   localparam int         DUTY_LOW_LO      = 4;
   localparam logic [1:0] PWM_SELECT       = 2'h3;
   localparam int         PWM_SEL_HI       = 3;
   localparam int         PWM_SEL_LO       = 2;
   localparam int         POL_PRIMARY      = 1;
   localparam int         POL_COMPLEMENT   = 0;
   localparam int         TIMER_ON_BIT     = 2;
   localparam int         TIMER_CTRL_W     = 3;
   localparam logic [1:0] PRESC_1          = 2'h0;
   localparam logic [1:0] PRESC_4          = 2'h1;
   localparam logic [3:0] PRESC_MAX_1      = 4'h0;
   localparam logic [3:0] PRESC_MAX_4      = 4'h3;
   localparam logic [3:0] PRESC_MAX_16     = 4'hF;
   localparam int         FLAG_BIT         = 0;
   localparam int         RESTART_BIT      = 7;
   localparam int         DB_COUNT_W       = 7;
   localparam int         STATUS_BIT       = 7;
   localparam int         SRC_INT_BIT      = 6;
   localparam int         SRC_CMP_BIT      = 4;
   localparam int         PSS_P_HI         = 3;
   localparam int         PSS_P_LO         = 2;
   localparam int         PSS_C_HI         = 1;
   localparam int         PSS_C_LO         = 0;
   localparam int         PIN_DIR_W        = 2;
   localparam int         DIR_PRIMARY      = 0;
   localparam int         DIR_COMPLEMENT   = 1;
   localparam int         CMP_SYNC_BIT     = 0;
   localparam logic [7:0] PERIOD_LIMIT_RST = 8'hFF;
   localparam logic [1:0] PIN_DIR_RST      = 2'h3;
   localparam logic [1:0] INT_SYNC_RST     = 2'h3;
   localparam logic       AHB_OKAY         = 1'b0;
   // -----------------------------------------------------------------
   // timing: one instruction cycle is four clock periods
   // -----------------------------------------------------------------
   localparam int         CLKS_PER_INSN    = 4;
   localparam int         DB_CNT_W         = DB_COUNT_W + 2;
   typedef logic [DB_CNT_W-1:0] db_cnt_t;
   typedef enum logic [2:0] {
      BUS_IDLE  = 3'h1,
      BUS_WRITE = 3'h2,
      BUS_READ  = 3'h4
   } bus_e;
endpackage

//--- hw/dead_band_if.sv
// link between the pwm core and one dead-band delay stage
`timescale 1ns/1ps
interface dead_band_if;
   logic                            in_active;
   logic [epwm_pkg::DB_COUNT_W-1:0] count;
   logic                            out_active;
   modport drv (output in_active, output count, input out_active);
   modport dly (input in_active, input count, output out_active);
endinterface

//--- hw/dead_band_delay.sv
// dead-band delay stage for one pwm output
`timescale 1ns/1ps
module dead_band_delay (
   input wire logic hclk,
   input wire logic hresetn,
   dead_band_if.dly link
);
   typedef struct packed {
      epwm_pkg::db_cnt_t cnt;
      logic              out;
   } dly_s;

   dly_s              s_q;
   dly_s              s_d;
   epwm_pkg::db_cnt_t target;

   assign target = epwm_pkg::db_cnt_t'(int'(link.count)
                   * epwm_pkg::CLKS_PER_INSN);
   assign link.out_active = s_q.out;

   // only the rising edge waits; falling passes at once
   always_comb begin
      s_d     = s_q;
      s_d.out = link.in_active && (s_q.cnt >= target);
      if (!link.in_active) begin
         s_d.cnt = '0;
      end else if (s_q.cnt < target) begin
         s_d.cnt = epwm_pkg::db_cnt_t'(s_q.cnt + 1'b1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_db_release : assert property (
      @(posedge hclk) disable iff (!hresetn)
      !link.in_active |=> !s_q.out)
      else $error("dead band output stayed active after release");

   a_db_hold : assert property (
      @(posedge hclk) disable iff (!hresetn)
      link.in_active && (s_q.cnt < target) |=> !s_q.out)
      else $error("dead band output went active too early");
endmodule

//--- testbench/switch_side.sv
// far-side model: switch drivers with pull-downs and shutdown sources
`timescale 1ns/1ps
module switch_side (
   input  wire logic hclk,
   input  wire logic int_low_req,
   input  wire logic cmp_high_req,
   input  wire logic prim_o,
   input  wire logic prim_oe,
   input  wire logic comp_o,
   input  wire logic comp_oe,
   output wire logic int_pin,
   output wire logic comparator_out,
   output wire logic aux_timer_tick,
   output wire logic prim_pin,
   output wire logic comp_pin
);
   logic [2:0] div_q = 3'h0;
   // pull-downs keep the switches off while the pins float
   assign prim_pin = prim_oe ? prim_o : 1'b0;
   assign comp_pin = comp_oe ? comp_o : 1'b0;
   // source levels persist for as long as the bench asks
   assign int_pin = ~int_low_req;
   assign comparator_out = cmp_high_req;
   assign aux_timer_tick = (div_q == 3'h7);
   always_ff @(posedge hclk) begin
      div_q <= div_q + 3'h1;
   end
endmodule

//--- testbench/enhanced_pwm_shutdown_tb.sv
// self-checking bench: register-level tests of the pwm stage
`timescale 1ns/1ps
module enhanced_pwm_shutdown_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        int_low_req = 1'b0;
   logic        cmp_high_req = 1'b0;
   logic [31:0] rdv;
   wire  logic  hready, hresp, ip, cp, tk, po, poe, co, coe, flag, pp, cpn;
   wire  logic [31:0] hrdata;
   int          bad_count = 0;
   int          check_count = 0;
   int          n;
   initial begin
      forever #10 hclk = ~hclk;
   end
   enhanced_pwm_shutdown uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hrdata(hrdata), .hresp(hresp), .int_pin(ip), .comparator_out(cp),
      .aux_timer_tick(tk), .primary_output_o(po), .primary_output_oe(poe),
      .complement_output_o(co), .complement_output_oe(coe),
      .period_timer_flag(flag));
   switch_side far (.hclk(hclk), .int_low_req(int_low_req),
      .cmp_high_req(cmp_high_req), .prim_o(po), .prim_oe(poe), .comp_o(co),
      .comp_oe(coe), .int_pin(ip), .comparator_out(cp),
      .aux_timer_tick(tk), .prim_pin(pp), .comp_pin(cpn));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // master holds each phase until hready is sampled high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rdv = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask
   // settles one period, then counts equal pin levels over two periods
   task count_same;
      n = 0;
      repeat (16) @(posedge hclk);
      repeat (32) begin
         @(posedge hclk);
         if (pp === cpn) n++;
      end
   endtask
   task tally_and_finish;
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk({30'h0, coe, poe}, 32'h0);
      rd_chk(epwm_pkg::OFS_PERIOD_LIMIT, 32'hFF);
      rd_chk(epwm_pkg::OFS_PIN_DIR, 32'h3);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h0);
      wr(epwm_pkg::ADDR_UNMAPPED, 32'hFF);
      rd_chk(epwm_pkg::ADDR_UNMAPPED, 32'h0);
      // period of 16 clocks, half duty, drivers kept off meanwhile
      wr(epwm_pkg::OFS_PERIOD_LIMIT, 32'h03);
      wr(epwm_pkg::OFS_CCP_CTRL, 32'h8C);
      wr(epwm_pkg::OFS_DUTY_HIGH, 32'h02);
      wr(epwm_pkg::OFS_TIMER_STAT, 32'h0);
      wr(epwm_pkg::OFS_TIMER_CTRL, 32'h04);
      rd_chk(epwm_pkg::OFS_TIMER_STAT, 32'h0);
      for (n = 0; n < 64 && flag !== 1'b1; n++) @(posedge hclk);
      rd_chk(epwm_pkg::OFS_TIMER_STAT, 32'h1);
      wr(epwm_pkg::OFS_PIN_DIR, 32'h0);
      // direction lands at the commit edge, enables one edge later
      repeat (2) @(posedge hclk);
      chk({30'h0, coe, poe}, 32'h3);
      count_same;
      chk(n, 0);
      wr(epwm_pkg::OFS_DB_CTRL, 32'h01);
      count_same;
      chk(n, 16);
      wr(epwm_pkg::OFS_DB_CTRL, 32'h03);
      count_same;
      chk(n, 32);
      wr(epwm_pkg::OFS_DB_CTRL, 32'h0);
      wr(epwm_pkg::OFS_CCP_CTRL, 32'h0C);
      repeat (2) @(posedge hclk);
      chk({31'h0, coe}, 32'h0);
      wr(epwm_pkg::OFS_CCP_CTRL, 32'h8C);
      wr(epwm_pkg::OFS_SHUT_CTRL, 32'h84);
      repeat (2) @(posedge hclk);
      chk({28'h0, po, poe, co, coe}, 32'hD);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h84);
      wr(epwm_pkg::OFS_SHUT_CTRL, 32'h49);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h49);
      int_low_req <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({28'h0, po, poe, co, coe}, 32'h3);
      wr(epwm_pkg::OFS_SHUT_CTRL, 32'h49);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'hC9);
      int_low_req <= 1'b0;
      repeat (4) @(posedge hclk);
      wr(epwm_pkg::OFS_SHUT_CTRL, 32'h49);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h49);
      wr(epwm_pkg::OFS_DB_CTRL, 32'h80);
      wr(epwm_pkg::OFS_SHUT_CTRL, 32'h10);
      cmp_high_req <= 1'b1;
      repeat (4) @(posedge hclk);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h90);
      cmp_high_req <= 1'b0;
      repeat (4) @(posedge hclk);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h10);
      // synced comparator: status waits for the next aux tick, 8 edges on
      wr(epwm_pkg::OFS_AUX_CTRL, 32'h1);
      while (tk !== 1'b1) @(posedge hclk);
      cmp_high_req <= 1'b1;
      repeat (4) @(posedge hclk);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h10);
      repeat (8) @(posedge hclk);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h90);
      cmp_high_req <= 1'b0;
      wr(epwm_pkg::OFS_AUX_CTRL, 32'h0);
      wr(epwm_pkg::OFS_SHUT_CTRL, 32'h20);
      int_low_req <= 1'b1;
      cmp_high_req <= 1'b1;
      repeat (4) @(posedge hclk);
      rd_chk(epwm_pkg::OFS_SHUT_CTRL, 32'h20);
      wr(epwm_pkg::OFS_CCP_CTRL, 32'h0);
      repeat (2) @(posedge hclk);
      chk({30'h0, coe, poe}, 32'h0);
      tally_and_finish;
   end
endmodule
